// ---- verilog/bcd_consts.svh ----
// Register offsets, field positions, reset values and timing for the bridge.
`ifndef BCD_CONSTS_SVH
`define BCD_CONSTS_SVH

`define BCD_OFS_CONFVR      8'hb0
`define BCD_OFS_CAPTURED    8'hb4
`define BCD_OFS_SYSTEM_MGMT_RAM       8'hb8
`define BCD_OFS_BIOS        8'hbc

`define BCD_CAP_W           16
`define BCD_STRAP_MSB       12
`define BCD_STRAP_LSB       5
`define BCD_CLUSTER_MSB     12
`define BCD_CLUSTER_LSB     11
`define BCD_BUS_INIT_N_BIT       10
`define BCD_BUS_ERROR_N_BIT        9
`define BCD_ADDRESS_PARITY_ERROR_N_BIT        8
`define BCD_IOQ_BIT         7
`define BCD_RSTVEC_BIT      6
`define BCD_FRC_BIT         5
`define BCD_CONFVR_RST      8'h00

`define BCD_SIZE_MSB        31
`define BCD_SIZE_LSB        28
`define BCD_BASE_MSB        15
`define BCD_BASE_LSB        0
`define BCD_SIZE_RST        4'h0
`define BCD_BASE_RST        16'h0005
`define BCD_BASE_SHIFT      17
`define BCD_UNIT_SHIFT      16

`define BCD_BIOS_LOW_BIT    4
`define BCD_BIOS_HIGH_BIT   0
`define BCD_BIOS_LOW_RST    1'b0
`define BCD_BIOS_HIGH_RST   1'b1

`define BCD_LOW_LO          36'h0_0000_0000
`define BCD_LOW_HI          36'h0_0007_ffff
`define BCD_HIGH_LO         36'h0_ffe0_0000
`define BCD_HIGH_HI         36'h0_ffff_ffff

`define BCD_CLK_NS          10
`define BCD_HRST_NS         1000
`define BCD_HRST_CNT_W      8

`endif

// ---- verilog/bcd_pkg.sv ----
// Types shared by the bridge configuration and decode logic.
package bcd_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_DRIVE = 3'b010,
        ST_HOLD  = 3'b100
    } bcd_hrst_state_type;

endpackage : bcd_pkg

// ---- verilog/bcd_strap_cap.sv ----
// Strap capture of host address lines at the release of host reset.
`timescale 1ns/1ps
`include "bcd_consts.svh"

module bcd_strap_cap
    import bcd_pkg::*;
(
    input  wire logic                 i_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_host_rst_n,
    input  wire logic [`BCD_STRAP_MSB:`BCD_STRAP_LSB] i_host_a_n,
    output logic [`BCD_CAP_W-1:0]     o_captured
);

    logic                 rst_n_prev_r;
    logic                 rise;
    logic [`BCD_CAP_W-1:0] cap_nxt;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rst_n_prev_r <= 1'b1;
        end else begin
            rst_n_prev_r <= i_host_rst_n;
        end
    end

    assign rise = i_host_rst_n && !rst_n_prev_r;

    // The pins are low active, so a low line reads back as a one.
    always_comb begin
        cap_nxt = '0;
        cap_nxt[`BCD_CLUSTER_MSB:`BCD_CLUSTER_LSB] =
            ~i_host_a_n[`BCD_CLUSTER_MSB:`BCD_CLUSTER_LSB]; // [R3]
        cap_nxt[`BCD_BUS_INIT_N_BIT]  = ~i_host_a_n[`BCD_BUS_INIT_N_BIT];  // [R4]
        cap_nxt[`BCD_BUS_ERROR_N_BIT]   = ~i_host_a_n[`BCD_BUS_ERROR_N_BIT];   // [R5]
        cap_nxt[`BCD_ADDRESS_PARITY_ERROR_N_BIT]   = ~i_host_a_n[`BCD_ADDRESS_PARITY_ERROR_N_BIT];   // [R6]
        cap_nxt[`BCD_IOQ_BIT]    = ~i_host_a_n[`BCD_IOQ_BIT];    // [R7]
        cap_nxt[`BCD_RSTVEC_BIT] = ~i_host_a_n[`BCD_RSTVEC_BIT]; // [R8]
        cap_nxt[`BCD_FRC_BIT]    = ~i_host_a_n[`BCD_FRC_BIT];    // [R9]
    end

    // No reset here: the content is only what the last capture saw.
    always_ff @(posedge i_clk) begin
        if (rise) begin
            o_captured <= cap_nxt; // [R1] [R2]
        end
    end

    property p_cap_on_rise;
        @(posedge i_clk) disable iff (i_rst)
        rise |=> o_captured[`BCD_STRAP_MSB:`BCD_STRAP_LSB]
                 == ~$past(i_host_a_n);
    endproperty
    a_cap_on_rise: assert property (p_cap_on_rise) // [R1]
        else $error("Straps not captured at host reset release.");

    property p_cap_stable;
        @(posedge i_clk) disable iff (i_rst)
        !rise ##1 $past(rise) == 1'b0 |-> $stable(o_captured);
    endproperty
    a_cap_stable: assert property (p_cap_stable) // [R2]
        else $error("Captured straps changed without a reset release.");

endmodule : bcd_strap_cap

// ---- verilog/bcd_top.sv ----
// Bridge configuration registers: strap capture, SYSTEM_MGMT_RAM range, BIOS decode.
// Overview of operation
// [R1] Straps captured from host address lines when host reset rises; read only.
// [R2] Captured register has no reset value, only the last capture.
// [R3] Bits 12:11 hold interrupt controller cluster id from lines 12:11.
// [R4] Bit 10 holds bus-init input enable from line ten.
// [R5] Bit 9 holds bus-error input enable from line nine.
// [R6] Bit 8 holds address parity error input enable from line eight.
// [R7] Bit 7 selects in-order queue depth: one is eight, zero is one.
// [R8] Bit 6 selects reset vector: one is 1 MB, zero is 4 GB.
// [R9] Bit 5 holds redundancy check mode enable from line five.
// [R10] Software keeps error output enables consistent with captured enables.
// [R11] SYSTEM_MGMT_RAM bits 31:28 give size in 64 KB steps, 64 KB to 1 MB.
// [R12] SYSTEM_MGMT_RAM bits 15:0 give the start address in 64 KB units; the code uses bits 14:0 in 128 KB units.
// [R13] SYSTEM_MGMT_RAM range register resets to 0000_0005h.
// [R14] Software writes zeros to SYSTEM_MGMT_RAM bits 27:16.
// [R15] Software programs SYSTEM_MGMT_RAM range where it overlaps PCI addresses.
// [R16] Enabled BIOS range: forward host accesses to PCI, ignore PCI ones.
// [R17] Disabled BIOS range: ignore host accesses, forward PCI ones to host.
// [R18] BIOS register bit 4 enables the 0 to 512 KB range.
// [R19] BIOS register bit 0 enables the 2 MB high BIOS window.
// [R20] Programmed hard reset drives stored straps while host reset is low.
// [R21] SYSTEM_MGMT_RAM hit when start <= address < start plus encoded size.
// [R22] Reserved bits of captured and BIOS registers read as zero.
`timescale 1ns/1ps
`include "bcd_consts.svh"

module bcd_top
    import bcd_pkg::*;
(
    input  wire logic         I_REF_CLK,
    input  wire logic         I_RST,
    input  wire logic         I_CFG_RD,
    input  wire logic         I_CFG_WR,
    input  wire logic [7:0]   I_CFG_ADDR,
    input  wire logic [3:0]   I_CFG_BE,
    input  wire logic [31:0]  I_CFG_WDATA,
    output logic [31:0]       O_CFG_RDATA,
    input  wire logic         I_HARD_RST_REQ,
    input  wire logic         I_HOST_RST_N,
    input  wire logic [`BCD_STRAP_MSB:`BCD_STRAP_LSB] I_HOST_A_N,
    output logic              O_HOST_RST_N,
    output logic [`BCD_STRAP_MSB:`BCD_STRAP_LSB] O_HOST_A_N,
    output logic              O_HOST_A_OE,
    input  wire logic         I_HMEM_REQ,
    input  wire logic [35:0]  I_HMEM_ADDR,
    input  wire logic         I_PMEM_REQ,
    input  wire logic [31:0]  I_PMEM_ADDR,
    output logic              O_HOST_TO_PCI,
    output logic              O_PCI_TO_HOST,
    output logic              O_SYSTEM_MGMT_RAM_HIT
);

    localparam int HRST_CYC =
        (`BCD_HRST_NS + `BCD_CLK_NS - 1) / `BCD_CLK_NS;
    localparam int HRST_GAP = HRST_CYC - 7;
    localparam logic [`BCD_HRST_CNT_W-1:0] HRST_LAST =
        `BCD_HRST_CNT_W'(HRST_CYC - 1);

    bcd_hrst_state_type              state_r;
    logic [`BCD_HRST_CNT_W-1:0]      cnt_r;
    logic [`BCD_STRAP_MSB:`BCD_STRAP_LSB] confvr_r;
    logic [3:0]                      size_r;
    logic [15:0]                     base_r;
    logic                            bios_low_r;
    logic                            bios_high_r;
    logic [`BCD_CAP_W-1:0]           captured;
    logic [7:0]                      word_addr;
    logic [31:0]                     rd_mux;
    logic [35:0]                     pci_addr36;
    logic [35:0]                     system_mgmt_ram_lo;
    logic [35:0]                     system_mgmt_ram_end;

    function automatic logic in_range(input logic [35:0] a,
                                      input logic [35:0] lo,
                                      input logic [35:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : in_range

    assign word_addr  = {I_CFG_ADDR[7:2], 2'b00};
    assign pci_addr36 = {4'h0, I_PMEM_ADDR};

    bcd_strap_cap u_cap (
        .i_clk        (I_REF_CLK),
        .i_rst        (I_RST),
        .i_host_rst_n (I_HOST_RST_N),
        .i_host_a_n   (I_HOST_A_N),
        .o_captured   (captured)
    );

    // Strap values driven on the host bus during a hard reset.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            confvr_r <= `BCD_CONFVR_RST;
        end else if (I_CFG_WR && word_addr == `BCD_OFS_CONFVR) begin
            if (I_CFG_BE[0]) begin
                confvr_r[`BCD_IOQ_BIT:`BCD_STRAP_LSB] <=
                    I_CFG_WDATA[`BCD_IOQ_BIT:`BCD_STRAP_LSB];
            end
            if (I_CFG_BE[1]) begin
                confvr_r[`BCD_STRAP_MSB:`BCD_ADDRESS_PARITY_ERROR_N_BIT] <=
                    I_CFG_WDATA[`BCD_STRAP_MSB:`BCD_ADDRESS_PARITY_ERROR_N_BIT];
            end
        end
    end

    // SYSTEM_MGMT_RAM range; bits 27:16 are not stored and read as zero.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            size_r <= `BCD_SIZE_RST; // [R13]
            base_r <= `BCD_BASE_RST; // [R13]
        end else if (I_CFG_WR && word_addr == `BCD_OFS_SYSTEM_MGMT_RAM) begin
            if (I_CFG_BE[3]) begin
                size_r <= I_CFG_WDATA[`BCD_SIZE_MSB:`BCD_SIZE_LSB]; // [R11]
            end
            if (I_CFG_BE[1]) begin
                base_r[15:8] <= I_CFG_WDATA[15:8]; // [R12]
            end
            if (I_CFG_BE[0]) begin
                base_r[7:0] <= I_CFG_WDATA[7:0]; // [R12]
            end
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            bios_low_r  <= `BCD_BIOS_LOW_RST;
            bios_high_r <= `BCD_BIOS_HIGH_RST;
        end else if (I_CFG_WR && word_addr == `BCD_OFS_BIOS
                     && I_CFG_BE[0]) begin
            bios_low_r  <= I_CFG_WDATA[`BCD_BIOS_LOW_BIT];  // [R18]
            bios_high_r <= I_CFG_WDATA[`BCD_BIOS_HIGH_BIT]; // [R19]
        end
    end

    always_comb begin
        rd_mux = '0;
        case (word_addr)
            `BCD_OFS_CONFVR: begin
                rd_mux[`BCD_STRAP_MSB:`BCD_STRAP_LSB] = confvr_r;
            end
            `BCD_OFS_CAPTURED: begin
                rd_mux[`BCD_CAP_W-1:0] = captured; // [R1] [R22]
            end
            `BCD_OFS_SYSTEM_MGMT_RAM: begin
                rd_mux[`BCD_SIZE_MSB:`BCD_SIZE_LSB] = size_r;
                rd_mux[`BCD_BASE_MSB:`BCD_BASE_LSB] = base_r;
            end
            `BCD_OFS_BIOS: begin
                rd_mux[`BCD_BIOS_LOW_BIT]  = bios_low_r;  // [R22]
                rd_mux[`BCD_BIOS_HIGH_BIT] = bios_high_r; // [R22]
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_CFG_RDATA <= '0;
        end else if (I_CFG_RD) begin
            O_CFG_RDATA <= rd_mux;
        end
    end

    // Host reset sequencer; power-on reset also starts a drive phase.
    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            state_r <= ST_DRIVE;
            cnt_r   <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    cnt_r <= '0;
                    if (I_HARD_RST_REQ) begin
                        state_r <= ST_DRIVE;
                    end
                end
                ST_DRIVE: begin
                    if (cnt_r == HRST_LAST) begin
                        state_r <= ST_HOLD;
                        cnt_r   <= '0;
                    end else begin
                        cnt_r <= cnt_r + 1'b1;
                    end
                end
                ST_HOLD: begin
                    state_r <= ST_IDLE;
                end
                default: begin
                    state_r <= ST_IDLE;
                    cnt_r   <= '0;
                end
            endcase
        end
    end

    // Straps stay on the lines for the release cycle so the capture sees them.
    assign O_HOST_RST_N = (state_r != ST_DRIVE);
    assign O_HOST_A_OE  = (state_r == ST_DRIVE)
                          || (state_r == ST_HOLD); // [R20]
    assign O_HOST_A_N   = ~confvr_r; // [R20]

    // SYSTEM_MGMT_RAM window bounds: start in 128 KB address steps, size in 64 KB.
    assign system_mgmt_ram_lo  = {4'h0, base_r[14:0], 17'h0}; // [R12]
    assign system_mgmt_ram_end = system_mgmt_ram_lo
                       + {15'h0, {1'b0, size_r} + 5'h1, 16'h0}; // [R11]

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_SYSTEM_MGMT_RAM_HIT <= 1'b0;
        end else begin
            O_SYSTEM_MGMT_RAM_HIT <= I_HMEM_REQ && (I_HMEM_ADDR >= system_mgmt_ram_lo)
                           && (I_HMEM_ADDR < system_mgmt_ram_end); // [R21]
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_HOST_TO_PCI <= 1'b0;
        end else begin
            O_HOST_TO_PCI <= I_HMEM_REQ && (
                (bios_low_r
                 && in_range(I_HMEM_ADDR, `BCD_LOW_LO, `BCD_LOW_HI))
                || (bios_high_r
                 && in_range(I_HMEM_ADDR, `BCD_HIGH_LO, `BCD_HIGH_HI))
            ); // [R16] [R17]
        end
    end

    always_ff @(posedge I_REF_CLK or posedge I_RST) begin
        if (I_RST) begin
            O_PCI_TO_HOST <= 1'b0;
        end else begin
            O_PCI_TO_HOST <= I_PMEM_REQ && (
                (!bios_low_r
                 && in_range(pci_addr36, `BCD_LOW_LO, `BCD_LOW_HI))
                || (!bios_high_r
                 && in_range(pci_addr36, `BCD_HIGH_LO, `BCD_HIGH_HI))
            ); // [R16] [R17]
        end
    end

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (I_RST);

    sequence s_rd_captured;
        I_CFG_RD && word_addr == `BCD_OFS_CAPTURED;
    endsequence

    property p_rd_cluster;
        s_rd_captured |=> O_CFG_RDATA[`BCD_CLUSTER_MSB:`BCD_CLUSTER_LSB]
                          == captured[`BCD_CLUSTER_MSB:`BCD_CLUSTER_LSB];
    endproperty
    a_rd_cluster: assert property (p_rd_cluster) // [R3]
        else $error("Cluster id readback wrong.");

    property p_rsv_zero;
        s_rd_captured |=> O_CFG_RDATA[31:13] == '0
                          && O_CFG_RDATA[4:0] == '0;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) // [R22]
        else $error("Reserved captured bits not zero.");

    property p_bios_rsv;
        I_CFG_RD && word_addr == `BCD_OFS_BIOS
        |=> O_CFG_RDATA[31:5] == '0 && O_CFG_RDATA[3:1] == '0;
    endproperty
    a_bios_rsv: assert property (p_bios_rsv) // [R22]
        else $error("Reserved BIOS bits not zero.");

    property p_host_fwd_high;
        I_HMEM_REQ && bios_high_r
        && in_range(I_HMEM_ADDR, `BCD_HIGH_LO, `BCD_HIGH_HI)
        |=> O_HOST_TO_PCI;
    endproperty
    a_host_fwd_high: assert property (p_host_fwd_high) // [R16]
        else $error("Enabled high window not forwarded to PCI.");

    property p_pci_fwd_low;
        I_PMEM_REQ && !bios_low_r && I_HMEM_ADDR == pci_addr36
        && in_range(pci_addr36, `BCD_LOW_LO, `BCD_LOW_HI)
        |=> O_PCI_TO_HOST && !O_HOST_TO_PCI;
    endproperty
    a_pci_fwd_low: assert property (p_pci_fwd_low) // [R17]
        else $error("Disabled low range not forwarded to host.");

    property p_bios_write;
        I_CFG_WR && word_addr == `BCD_OFS_BIOS && I_CFG_BE[0]
        ##2 I_PMEM_REQ && I_PMEM_ADDR == 32'h0000_0000
        |=> O_PCI_TO_HOST == !$past(I_CFG_WDATA[`BCD_BIOS_LOW_BIT], 3);
    endproperty
    a_bios_write: assert property (p_bios_write) // [R18]
        else $error("Low range enable bit does not steer decode.");

    property p_system_mgmt_ram_hit;
        I_HMEM_REQ && I_HMEM_ADDR == system_mgmt_ram_lo |=> O_SYSTEM_MGMT_RAM_HIT;
    endproperty
    a_system_mgmt_ram_hit: assert property (p_system_mgmt_ram_hit) // [R21]
        else $error("Start of SYSTEM_MGMT_RAM range missed.");

    property p_system_mgmt_ram_end;
        I_HMEM_REQ && I_HMEM_ADDR == system_mgmt_ram_end |=> !O_SYSTEM_MGMT_RAM_HIT;
    endproperty
    a_system_mgmt_ram_end: assert property (p_system_mgmt_ram_end) // [R11]
        else $error("Address past SYSTEM_MGMT_RAM range reported as hit.");

    property p_drive_in_rst;
        !O_HOST_RST_N |-> O_HOST_A_OE && O_HOST_A_N == ~confvr_r;
    endproperty
    a_drive_in_rst: assert property (p_drive_in_rst) // [R20]
        else $error("Straps not driven while host reset is low.");

    sequence s_hrst_low;
        (!O_HOST_RST_N)[*8] ##HRST_GAP O_HOST_RST_N && O_HOST_A_OE;
    endsequence

    property p_hrst_len;
        state_r == ST_IDLE && I_HARD_RST_REQ |=> s_hrst_low;
    endproperty
    a_hrst_len: assert property (p_hrst_len) // [R20]
        else $error("Host reset pulse length wrong.");

endmodule : bcd_top

// ---- tb/bcd_host_agents.sv ----
// Host bus agents: reset loopback and strap lines seen on the host bus.
`timescale 1ns/1ps

module bcd_host_agents (
    input  wire logic        i_clk,
    input  wire logic        i_rst_drive_n,
    input  wire logic        i_a_oe,
    input  wire logic [12:5] i_a_n,
    output logic             o_rst_n,
    output logic [12:5]      o_a_n
);
    logic [12:5] idle_r;

    // Released lines flip every cycle so a stale value is never mistaken.
    always_ff @(posedge i_clk) begin
        idle_r <= ~o_a_n;
    end

    assign o_rst_n = i_rst_drive_n;
    assign o_a_n   = i_a_oe ? i_a_n : idle_r;
endmodule : bcd_host_agents

// ---- tb/bcd_top_tb.sv ----
// Self-checking testbench for the bridge configuration and decode block.
`timescale 1ns/1ps

module bcd_top_tb;
    logic        clk;
    logic        rst;
    logic        cfg_rd;
    logic        cfg_wr;
    logic        hrst_req;
    logic        hmem_req;
    logic        pmem_req;
    logic [7:0]  cfg_addr;
    logic [3:0]  cfg_be;
    logic [31:0] cfg_wdata;
    logic [31:0] cfg_rdata;
    logic [31:0] pmem_addr;
    logic [35:0] hmem_addr;
    logic        rst_n_in;
    logic        rst_n_out;
    logic        a_oe;
    logic [12:5] a_n_in;
    logic [12:5] a_n_out;
    logic        to_pci;
    logic        to_host;
    logic        system_mgmt_ram_hit;
    int          miscompares = 0;
    int          cmp_count = 0;
    int          cycles = 0;

    bcd_top dut (.I_REF_CLK(clk), .I_RST(rst), .I_CFG_RD(cfg_rd),
        .I_CFG_WR(cfg_wr), .I_CFG_ADDR(cfg_addr), .I_CFG_BE(cfg_be),
        .I_CFG_WDATA(cfg_wdata), .O_CFG_RDATA(cfg_rdata),
        .I_HARD_RST_REQ(hrst_req), .I_HOST_RST_N(rst_n_in),
        .I_HOST_A_N(a_n_in), .O_HOST_RST_N(rst_n_out),
        .O_HOST_A_N(a_n_out), .O_HOST_A_OE(a_oe),
        .I_HMEM_REQ(hmem_req), .I_HMEM_ADDR(hmem_addr),
        .I_PMEM_REQ(pmem_req), .I_PMEM_ADDR(pmem_addr),
        .O_HOST_TO_PCI(to_pci), .O_PCI_TO_HOST(to_host),
        .O_SYSTEM_MGMT_RAM_HIT(system_mgmt_ram_hit));

    bcd_host_agents agents (.i_clk(clk), .i_rst_drive_n(rst_n_out),
        .i_a_oe(a_oe), .i_a_n(a_n_out), .o_rst_n(rst_n_in),
        .o_a_n(a_n_in));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            stop_test();
        end
    end

    task automatic check(input string what, input logic [35:0] exp,
                         input logic [35:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    task automatic cfg_write(input logic [7:0] a, input logic [3:0] be,
                             input logic [31:0] d);
        @(negedge clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_be = be;
        cfg_wdata = d;
        @(negedge clk);
        cfg_wr = 1'b0;
    endtask : cfg_write

    task automatic expect_reg(input logic [7:0] a, input logic [31:0] exp);
        @(negedge clk);
        cfg_rd = 1'b1;
        cfg_addr = a;
        @(negedge clk);
        cfg_rd = 1'b0;
        check($sformatf("register %h", a), {4'h0, exp}, {4'h0, cfg_rdata});
    endtask : expect_reg

    // Host and PCI requests in one cycle; PCI gets the low 32 bits of the address.
    task automatic access(input logic [35:0] a, input logic h2p,
                          input logic p2h, input logic hit);
        @(negedge clk);
        hmem_req = 1'b1;
        pmem_req = 1'b1;
        hmem_addr = a;
        pmem_addr = a[31:0];
        @(negedge clk);
        hmem_req = 1'b0;
        pmem_req = 1'b0;
        check($sformatf("host claim %h", a), {35'h0, h2p}, {35'h0, to_pci});
        check($sformatf("pci claim %h", a), {35'h0, p2h}, {35'h0, to_host});
        check($sformatf("system_mgmt_ram hit %h", a), {35'h0, hit}, {35'h0, system_mgmt_ram_hit});
        @(negedge clk);
        check("pulse end", 36'h0, {33'h0, to_pci, to_host, system_mgmt_ram_hit});
    endtask : access

    task automatic t_defaults();
        expect_reg(8'hb8, 32'h0000_0005);
        expect_reg(8'hbc, 32'h0000_0001);
        expect_reg(8'h40, 32'h0000_0000);
        $display("test defaults done");
    endtask : t_defaults

    task automatic t_capture();
        logic [15:0] pat [3] = '{16'h15a0, 16'h0a40, 16'hffff};
        repeat (110) @(negedge clk);
        expect_reg(8'hb4, 32'h0000_0000);
        for (int i = 0; i < 3; i++) begin
            cfg_write(8'hb0, 4'h3, {16'h0, pat[i]});
            @(negedge clk);
            hrst_req = 1'b1;
            @(negedge clk);
            hrst_req = 1'b0;
            repeat (50) @(negedge clk);
            // Mid drive phase: host reset low and the straps driven.
            check("reset drive", 36'h1, {34'h0, rst_n_out, a_oe});
            check("strap drive", {28'h0, ~pat[i][12:5]},
                  {28'h0, a_n_out});
            repeat (60) @(negedge clk);
            check("drive release", 36'h2, {34'h0, rst_n_out, a_oe});
            expect_reg(8'hb4, {16'h0, pat[i] & 16'h1fe0});
            // The same readback lets software match its error enables.
            expect_reg(8'hb4, {16'h0, pat[i] & 16'h1fe0});
            expect_reg(8'hb4, {16'h0, pat[i] & 16'h1fe0});
        end
        cfg_write(8'hb4, 4'hf, 32'h0000_0000);
        expect_reg(8'hb4, 32'h0000_1fe0);
        $display("test capture done");
    endtask : t_capture

    task automatic t_system_mgmt_ram();
        access(36'h0_000a_0000, 1'b0, 1'b0, 1'b1);
        access(36'h0_0009_ffff, 1'b0, 1'b0, 1'b0);
        cfg_write(8'hb8, 4'hf, 32'h3000_0010);
        expect_reg(8'hb8, 32'h3000_0010);
        access(36'h0_001f_ffff, 1'b0, 1'b0, 1'b0);
        access(36'h0_0020_0000, 1'b0, 1'b0, 1'b1);
        access(36'h0_0023_ffff, 1'b0, 1'b0, 1'b1);
        access(36'h0_0024_0000, 1'b0, 1'b0, 1'b0);
        cfg_write(8'hb8, 4'hf, 32'hf000_ffff);
        expect_reg(8'hb8, 32'hf000_ffff);
        access(36'h0_fffe_0000, 1'b1, 1'b0, 1'b1);
        access(36'h1_000d_ffff, 1'b0, 1'b0, 1'b1);
        access(36'h1_000e_0000, 1'b0, 1'b0, 1'b0);
        $display("test system_mgmt_ram done");
    endtask : t_system_mgmt_ram

    task automatic t_bios();
        logic [1:0] e;
        for (int i = 0; i < 4; i++) begin
            e = i[1:0];
            cfg_write(8'hbc, 4'h1, {27'h0, e[1], 3'h0, e[0]});
            // Decode right after the write, two cycles behind it.
            access(36'h0_0000_0000, e[1], ~e[1], 1'b0);
            expect_reg(8'hbc, {27'h0, e[1], 3'h0, e[0]});
            access(36'h0_0007_ffff, e[1], ~e[1], 1'b0);
            access(36'h0_0008_0000, 1'b0, 1'b0, 1'b0);
            access(36'h0_ffe0_0000, e[0], ~e[0], 1'b0);
            access(36'h0_ffdf_ffff, 1'b0, 1'b0, 1'b0);
            access(36'h1_ffe0_0000, 1'b0, ~e[0], 1'b0);
        end
        cfg_write(8'hbc, 4'hf, 32'hffff_ffff);
        expect_reg(8'hbc, 32'h0000_0011);
        $display("test bios done");
    endtask : t_bios

    initial begin
        rst = 1'b1;
        cfg_rd = 1'b0;
        cfg_wr = 1'b0;
        cfg_addr = 8'h00;
        cfg_be = 4'h0;
        cfg_wdata = 32'h0;
        hrst_req = 1'b0;
        hmem_req = 1'b0;
        pmem_req = 1'b0;
        hmem_addr = 36'h0;
        pmem_addr = 32'h0;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        t_defaults();
        t_capture();
        t_system_mgmt_ram();
        t_bios();
        stop_test();
    end
endmodule : bcd_top_tb
